// file: pwm_edge_timing.sv
// edge timing registers and drive outputs b, c and d
// Notes on behaviour
// - edge time: high byte plus setting bits 7:4
// - one count moves the edge 5 ns
// - modulation acts only when bit 3 set
// - bit 2 high: modulation moves edge later
// - bit 2 low: modulation moves edge earlier
// - b falling edge from 0x47 and 0x48
// - c rising edge from 0x49 and 0x4A
// - c falling edge from 0x4B and 0x4C
// - d rising low bits from 0x4E nibble
// - d rising high byte held at 0x4D
`timescale 1ns/100ps
module pwm_edge_timing (
	input  wire logic                            clock,             // 20 MHz system clock
	input  wire logic                            srst,              // sync reset, high
	input  wire logic [pwm_edge_pkg::ADDR_W-1:0] reg_addr,          // register address
	input  wire logic [pwm_edge_pkg::REG_W-1:0]  reg_wdata,         // write data
	input  wire logic                            reg_we,            // write strobe
	input  wire logic                            reg_re,            // read strobe
	output logic [pwm_edge_pkg::REG_W-1:0]       reg_rdata,         // read data, registered
	input  wire logic [pwm_edge_pkg::TIME_W-1:0] period_ticks,      // period in 5 ns steps
	input  wire logic [pwm_edge_pkg::MOD_W-1:0]  mod_value,         // loop modulation
	input  wire logic [pwm_edge_pkg::TIME_W-1:0] drive_b_rise_time, // b rising edge time
	input  wire logic [pwm_edge_pkg::TIME_W-1:0] drive_d_fall_time, // d falling edge time
	output logic                                 drive_b_output,    // drive output b
	output logic                                 drive_c_output,    // drive output c
	output logic                                 drive_d_output,    // drive output d
	output logic                                 period_start       // first cycle of period
);
	import pwm_edge_pkg::*;

	// the counter steps several 5 ns counts per clock
	localparam logic [TIME_W:0] TICK_STEP = (TIME_W + 1)'(TICKS_PER_CLK);

	// refuse a clock that is not a whole number of steps
	if (CLK_NS % STEP_NS != 0 || TICKS_PER_CLK == 0) begin : g_bad_clock
		$error("clock period must be a whole multiple of the edge step");
	end
	if (MOD_W > TIME_W) begin : g_bad_mod
		$error("modulation wider than edge time");
	end

	logic [REG_W-1:0]  regs_q [NUM_REGS];    // programming registers
	logic [TIME_W-1:0] tick_q;               // position in period, 5 ns units
	logic [TIME_W:0]   tick_next;            // position one clock later
	logic              period_end;           // last clock of the period
	logic              addr_hit;             // address inside the map
	logic [2:0]        reg_idx;              // index within the map
	edge_cfg_s         cfgs [NUM_EDGES];     // pairs per edge
	logic [TIME_W-1:0] edge_times [NUM_EDGES]; // times in use this period
	logic              b_rise_hit;           // edge falls in this clock
	logic              b_fall_hit;
	logic              c_rise_hit;
	logic              c_fall_hit;
	logic              d_rise_hit;
	logic              d_fall_hit;
	logic              drive_b_q;            // output levels
	logic              drive_c_q;
	logic              drive_d_q;
	logic              period_start_q;       // boundary marker

	// decide whether an edge lands inside this clock's window of steps
	function automatic logic in_window(input logic [TIME_W-1:0] t,
	                                   input logic [TIME_W-1:0] now);
		logic [TIME_W:0] lo;
		logic [TIME_W:0] hi;
		lo = {1'b0, now};
		hi = {1'b0, now} + TICK_STEP;
		return ({1'b0, t} >= lo) && ({1'b0, t} < hi);
	endfunction

	// new level given the edges that land in this clock
	function automatic logic next_level(input logic cur,
	                                    input logic rise_hit,
	                                    input logic fall_hit,
	                                    input logic [TIME_W-1:0] rise,
	                                    input logic [TIME_W-1:0] fall);
		logic lvl;
		lvl = cur;
		if (rise_hit && fall_hit) begin
			// both in one clock: the later edge decides
			lvl = (rise > fall);
		end else if (rise_hit) begin
			lvl = 1'b1;
		end else if (fall_hit) begin
			lvl = 1'b0;
		end
		return lvl;
	endfunction

	// address decode
	always_comb begin
		addr_hit = 1'b0;
		reg_idx  = 3'h0;
		// the map is one contiguous run, so a subtraction gives the slot
		if (reg_addr >= ADDR_FIRST && reg_addr <= ADDR_LAST) begin
			addr_hit = 1'b1;
			reg_idx  = 3'(reg_addr - ADDR_FIRST);
		end else begin
			addr_hit = 1'b0;
		end
	end

	// register writes; bits 1:0 are stored as written
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= REG_RESET;
			end
		end else if (reg_we && addr_hit) begin
			// reserved low bits kept as software wrote them
			regs_q[reg_idx] <= reg_wdata;
		end
	end

	// read data held until the next read
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= REG_RESET;
		end else if (reg_re) begin
			if (addr_hit) begin
				reg_rdata <= regs_q[reg_idx];
			end else begin
				// outside the map reads zero
				reg_rdata <= REG_RESET;
			end
		end
	end

	// period counter in 5 ns steps, several per clock
	// a period shorter than one clock of steps ends on every clock
	assign tick_next  = {1'b0, tick_q} + TICK_STEP;
	assign period_end = (tick_next >= {1'b0, period_ticks});

	always_ff @(posedge clock) begin
		if (srst) begin
			tick_q <= TIME_RESET;
		end else if (period_end) begin
			tick_q <= TIME_RESET;
		end else begin
			tick_q <= tick_next[TIME_W-1:0];
		end
	end

	// boundary marker for software and the loop
	always_ff @(posedge clock) begin
		if (srst) begin
			period_start_q <= 1'b0;
		end else begin
			period_start_q <= period_end;
		end
	end
	assign period_start = period_start_q;

	// pair each timing register with its setting register
	// each pair is held until the boundary, so write order does not matter
	for (genvar e = 0; e < NUM_EDGES; e++) begin : g_edge
		assign cfgs[e] = '{time_high: regs_q[2*e], setting: regs_q[2*e+1]};
		pwm_edge_calc u_calc (
			.clock     (clock),
			.srst      (srst),
			.load      (period_end),
			.cfg       (cfgs[e]),
			.mod_value (mod_value),
			.edge_time (edge_times[e])
		);
	end

	// which edges land in the current clock
	// a time at or past the period length rounded up to whole clocks never lands, so the level holds
	always_comb begin
		b_rise_hit = in_window(drive_b_rise_time, tick_q);
		b_fall_hit = in_window(edge_times[EDGE_B_FALL], tick_q);
		c_rise_hit = in_window(edge_times[EDGE_C_RISE], tick_q);
		c_fall_hit = in_window(edge_times[EDGE_C_FALL], tick_q);
		d_rise_hit = in_window(edge_times[EDGE_D_RISE], tick_q);
		d_fall_hit = in_window(drive_d_fall_time, tick_q);
	end

	// drive output b
	always_ff @(posedge clock) begin
		if (srst) begin
			drive_b_q <= 1'b0;
		end else begin
			drive_b_q <= next_level(drive_b_q, b_rise_hit, b_fall_hit,
				drive_b_rise_time, edge_times[EDGE_B_FALL]);
		end
	end

	// drive output c
	always_ff @(posedge clock) begin
		if (srst) begin
			drive_c_q <= 1'b0;
		end else begin
			drive_c_q <= next_level(drive_c_q, c_rise_hit, c_fall_hit,
				edge_times[EDGE_C_RISE], edge_times[EDGE_C_FALL]);
		end
	end

	// drive output d
	always_ff @(posedge clock) begin
		if (srst) begin
			drive_d_q <= 1'b0;
		end else begin
			drive_d_q <= next_level(drive_d_q, d_rise_hit, d_fall_hit,
				edge_times[EDGE_D_RISE], drive_d_fall_time);
		end
	end

	// outputs come straight from flops, one clock after the edge window
	assign drive_b_output = drive_b_q;
	assign drive_c_output = drive_c_q;
	assign drive_d_output = drive_d_q;

	// checks on the logic above
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	// helper: programmed c rise time as the registers hold it
	logic [TIME_W-1:0] c_rise_base;
	assign c_rise_base = {regs_q[2*EDGE_C_RISE],
		regs_q[2*EDGE_C_RISE+1][SET_NIB_HI:SET_NIB_LO]};

	reg_readback_a: assert property (
		(reg_we && reg_addr == ADDR_C_RISE_SETTING) ##1
		(reg_re && reg_addr == ADDR_C_RISE_SETTING && !reg_we)
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("setting register readback differs from write");

	unmapped_read_a: assert property (
		(reg_re && !addr_hit) |=> reg_rdata == REG_RESET)
		else $error("unmapped read not zero");

	tick_step_a: assert property (
		!period_end |=> tick_q == $past(tick_q) + TIME_W'(TICKS_PER_CLK))
		else $error("period counter did not step by one clock of steps");

	period_wrap_a: assert property (
		period_end |=> (tick_q == TIME_RESET) && period_start)
		else $error("period did not restart");

	coherent_load_a: assert property (
		$changed(edge_times[EDGE_C_RISE]) |-> $past(period_end))
		else $error("edge time changed inside a period");

	no_mod_a: assert property (
		(period_end && !regs_q[2*EDGE_C_RISE+1][SET_MOD_EN])
		|=> edge_times[EDGE_C_RISE] == $past(c_rise_base))
		else $error("unmodulated edge differs from programmed time");

	mod_later_a: assert property (
		(period_end && regs_q[2*EDGE_C_RISE+1][SET_MOD_EN]
		&& regs_q[2*EDGE_C_RISE+1][SET_DIR]
		&& ({1'b0, c_rise_base} + {5'h00, mod_value}) <= 13'h0FFF)
		|=> edge_times[EDGE_C_RISE] == $past(c_rise_base) + TIME_W'($past(mod_value)))
		else $error("edge did not move later by the modulation");

	mod_earlier_a: assert property (
		(period_end && regs_q[2*EDGE_C_RISE+1][SET_MOD_EN]
		&& !regs_q[2*EDGE_C_RISE+1][SET_DIR]
		&& c_rise_base >= TIME_W'(mod_value))
		|=> edge_times[EDGE_C_RISE] == $past(c_rise_base) - TIME_W'($past(mod_value)))
		else $error("edge did not move earlier by the modulation");

	rise_drives_high_a: assert property (
		(c_rise_hit && !c_fall_hit) |=> drive_c_output)
		else $error("output c not high after rising edge");

	fall_drives_low_a: assert property (
		(c_fall_hit && !c_rise_hit) |=> !drive_c_output)
		else $error("output c not low after falling edge");

	level_hold_a: assert property (
		(!d_rise_hit && !d_fall_hit) |=> $stable(drive_d_output))
		else $error("output d moved without an edge");

	// b falling and d rising edges reach their pins; d rising time loads from its register pair
	b_fall_low_a: assert property (
		(b_fall_hit && !b_rise_hit) |=> !drive_b_output)
		else $error("output b not low after falling edge");

	d_rise_high_a: assert property (
		(d_rise_hit && !d_fall_hit) |=> drive_d_output)
		else $error("output d not high after rising edge");

	d_pair_load_a: assert property (
		(period_end && !regs_q[2*EDGE_D_RISE+1][SET_MOD_EN])
		|=> edge_times[EDGE_D_RISE] == $past({regs_q[2*EDGE_D_RISE],
			regs_q[2*EDGE_D_RISE+1][SET_NIB_HI:SET_NIB_LO]}))
		else $error("output d rising time not from its register pair");

	// main scenarios
	pulse_c_c: cover property (
		$rose(drive_c_output) ##[1:400] $fell(drive_c_output));
	mod_later_c: cover property (
		period_end && regs_q[2*EDGE_B_FALL+1][SET_MOD_EN] && regs_q[2*EDGE_B_FALL+1][SET_DIR]);
	mod_earlier_c: cover property (
		period_end && regs_q[2*EDGE_D_RISE+1][SET_MOD_EN] && !regs_q[2*EDGE_D_RISE+1][SET_DIR]);
	both_edges_c: cover property (c_rise_hit && c_fall_hit);
endmodule

// file: pwm_edge_pkg.sv
// shared constants and types for the drive edge timing block
package pwm_edge_pkg;
	// widths
	localparam int unsigned TIME_W = 12;          // edge time width
	localparam int unsigned REG_W  = 8;           // register width
	localparam int unsigned MOD_W  = 8;           // loop modulation value width
	localparam int unsigned ADDR_W = 8;           // register address width

	// register offsets
	localparam logic [7:0] ADDR_B_FALL_TIME_HIGH = 8'h47; // drive_b_fall_time_high
	localparam logic [7:0] ADDR_B_FALL_SETTING   = 8'h48; // drive_b_fall_setting
	localparam logic [7:0] ADDR_C_RISE_TIME_HIGH = 8'h49; // drive_c_rise_time_high
	localparam logic [7:0] ADDR_C_RISE_SETTING   = 8'h4A; // drive_c_rise_setting
	localparam logic [7:0] ADDR_C_FALL_TIME_HIGH = 8'h4B; // drive_c_fall_time_high
	localparam logic [7:0] ADDR_C_FALL_SETTING   = 8'h4C; // drive_c_fall_setting
	localparam logic [7:0] ADDR_D_RISE_TIME_HIGH = 8'h4D; // drive_d_rise_time_high
	localparam logic [7:0] ADDR_D_RISE_SETTING   = 8'h4E; // drive_d_rise_setting
	localparam logic [7:0] ADDR_FIRST            = ADDR_B_FALL_TIME_HIGH;
	localparam logic [7:0] ADDR_LAST             = ADDR_D_RISE_SETTING;
	localparam int unsigned NUM_REGS             = 8;

	// setting register fields
	localparam int unsigned SET_NIB_HI = 7;       // low nibble of edge time, top bit
	localparam int unsigned SET_NIB_LO = 4;       // low nibble of edge time, bottom bit
	localparam int unsigned SET_MOD_EN = 3;       // modulation enable
	localparam int unsigned SET_DIR    = 2;       // 1: later with more modulation

	// reset values
	localparam logic [7:0]  REG_RESET  = 8'h00;
	localparam logic [11:0] TIME_RESET = 12'h000;

	// timing: one edge count is one step, the clock spans several steps
	localparam int unsigned STEP_NS       = 5;
	localparam int unsigned CLK_NS        = 50;
	localparam int unsigned TICKS_PER_CLK = CLK_NS / STEP_NS;

	// edge slots, two registers each starting at ADDR_FIRST
	localparam int unsigned EDGE_B_FALL = 0;
	localparam int unsigned EDGE_C_RISE = 1;
	localparam int unsigned EDGE_C_FALL = 2;
	localparam int unsigned EDGE_D_RISE = 3;
	localparam int unsigned NUM_EDGES   = 4;

	// one edge's programming pair
	typedef struct packed {
		logic [7:0] time_high;                        // eight high bits of the edge time
		logic [7:0] setting;                          // low nibble, enable, direction
	} edge_cfg_s;
endpackage

// file: pwm_edge_calc.sv
// one edge: assembles the 12-bit time and applies modulation at load
`timescale 1ns/100ps
module pwm_edge_calc (
	input  wire logic                           clock,      // system clock
	input  wire logic                           srst,       // sync reset, high
	input  wire logic                           load,       // period boundary strobe
	input  pwm_edge_pkg::edge_cfg_s             cfg,        // programmed pair
	input  wire logic [pwm_edge_pkg::MOD_W-1:0] mod_value,  // loop modulation
	output logic [pwm_edge_pkg::TIME_W-1:0]     edge_time   // time in use this period
);
	import pwm_edge_pkg::*;

	logic [TIME_W-1:0] base;     // programmed time
	logic [TIME_W:0]   later;    // base plus modulation, carry on top
	logic [TIME_W:0]   earlier;  // base minus modulation, borrow on top

	// high byte from the timing register, low nibble from the setting
	assign base    = {cfg.time_high, cfg.setting[SET_NIB_HI:SET_NIB_LO]};
	assign later   = {1'b0, base} + {{(TIME_W + 1 - MOD_W){1'b0}}, mod_value};
	assign earlier = {1'b0, base} - {{(TIME_W + 1 - MOD_W){1'b0}}, mod_value};

	// capture only at the boundary so both halves land together
	always_ff @(posedge clock) begin
		if (srst) begin
			edge_time <= TIME_RESET;
		end else if (load) begin
			if (!cfg.setting[SET_MOD_EN]) begin
				edge_time <= base;
			end else if (cfg.setting[SET_DIR]) begin
				// saturate rather than wrap to the period start
				edge_time <= later[TIME_W] ? {TIME_W{1'b1}} : later[TIME_W-1:0];
			end else begin
				edge_time <= earlier[TIME_W] ? TIME_RESET : earlier[TIME_W-1:0];
			end
		end
	end
endmodule

// file: gate_drive_model.sv
// gate driver stand-in: records where each drive output switches in its period
`timescale 1ns/100ps
module gate_drive_model (
	input  wire logic       clock,          // system clock
	input  wire logic       period_start,   // first clock of each period
	input  wire logic [2:0] drive_levels,   // outputs d, c, b as msb..lsb
	output logic [7:0]      rise_idx [3],   // clock index of last rise
	output logic [7:0]      fall_idx [3]    // clock index of last fall
);
	logic [7:0] cnt_q;                      // clocks since period start
	logic [2:0] prev_q;                     // levels of the previous clock

	// a gate driver only sees levels, so positions are kept in whole clocks
	always @(posedge clock) begin
		cnt_q = period_start ? 8'h00 : cnt_q + 8'h01;
		for (int i = 0; i < 3; i++) begin
			if (drive_levels[i] && !prev_q[i]) begin
				rise_idx[i] <= cnt_q;
			end
			if (!drive_levels[i] && prev_q[i]) begin
				fall_idx[i] <= cnt_q;
			end
		end
		prev_q <= drive_levels;
	end

	// start from a known state before the first period
	initial begin
		cnt_q = 8'h00;
		prev_q = 3'b000;
		rise_idx = '{default: 8'h00};
		fall_idx = '{default: 8'h00};
	end
endmodule

// file: test_pwm_edge_timing.sv
// self-checking bench for the drive edge timing block
`timescale 1ns/100ps
module test_pwm_edge_timing;
	import pwm_edge_pkg::*;
	logic                  clock, srst, reg_we, reg_re;      // clock, reset, strobes
	logic [ADDR_W-1:0]     reg_addr;                         // register address
	logic [REG_W-1:0]      reg_wdata, reg_rdata;             // register data
	logic [TIME_W-1:0]     period_ticks, b_rise, d_fall;     // live times
	logic [MOD_W-1:0]      mod_value;                        // modulation
	logic                  out_b, out_c, out_d, period_start; // outputs
	logic [7:0]            rise_idx [3], fall_idx [3];       // measured positions
	int                    mismatches, samples_checked;      // counters
	logic [7:0]            prog [8] = '{8'h09, 8'h60, 8'h01, 8'h40, 8'h03, 8'hC0, 8'h06, 8'h40};
	logic [7:0]            sets [4] = '{8'h40, 8'h44, 8'h48, 8'h4C};
	logic [11:0]           mexp [4] = '{12'd20, 12'd20, 12'd0, 12'd50};

	pwm_edge_timing u_pwm_edge_timing (.clock(clock), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.period_ticks(period_ticks), .mod_value(mod_value), .drive_b_rise_time(b_rise),
		.drive_d_fall_time(d_fall), .drive_b_output(out_b), .drive_c_output(out_c),
		.drive_d_output(out_d), .period_start(period_start));
	gate_drive_model u_gate_drive_model (.clock(clock), .period_start(period_start),
		.drive_levels({out_d, out_c, out_b}), .rise_idx(rise_idx), .fall_idx(fall_idx));

	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// one comparison, reported at once on a mismatch
	task chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// single-cycle write strobe; an edge passes first so strobes never re-rise in one step
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_we = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clock);
		#1 reg_we = 1'b0;
	endtask

	// read strobe; data is registered at the taking edge
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		#1 reg_re = 1'b1;
		reg_addr = a;
		@(posedge clock);
		#1 reg_re = 1'b0;
		chk({4'h0, reg_rdata}, {4'h0, exp});
	endtask

	// write, then read the same register back in the very next clock
	task wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_we = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clock);
		#1 reg_we = 1'b0;
		reg_re = 1'b1;
		@(posedge clock);
		#1 reg_re = 1'b0;
		chk({4'h0, reg_rdata}, {4'h0, d});
	endtask

	// bounded wait for the first clock of the n-th period ahead
	task wait_period(input int n);
		for (int p = 0; p < n; p++) begin
			int k;
			k = 0;
			do begin
				@(posedge clock);
				#1 k++;
			end while (period_start !== 1'b1 && k < 100);
			if (k >= 100) chk(12'hFFF, 12'h000);
		end
	endtask

	// an edge at time t shows at the output one clock after its window
	task edge_chk(input int i, input logic [11:0] r, input logic [11:0] f);
		chk({4'h0, rise_idx[i]}, r / TICKS_PER_CLK + 12'd1);
		chk({4'h0, fall_idx[i]}, f / TICKS_PER_CLK + 12'd1);
	endtask

	// verdict and end of run
	task test_done();
		$display("checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// hang guard, well beyond the few dozen periods of the run
	initial begin
		#(5000 * 50);
		mismatches++;
		test_done();
	end

	// main sequence
	initial begin
		mismatches = 0;
		samples_checked = 0;
		srst = 1'b1;
		{reg_we, reg_re, reg_addr, reg_wdata, mod_value} = '0;
		period_ticks = 12'd200;
		b_rise = 12'd10;
		d_fall = 12'd180;
		repeat (6) @(posedge clock);
		#1 srst = 1'b0;
		for (int i = 0; i < 8; i++) rd(ADDR_FIRST + 8'(i), REG_RESET);
		for (int i = 0; i < 8; i++) wr(ADDR_FIRST + 8'(i), prog[i]);
		for (int i = 0; i < 8; i++) rd(ADDR_FIRST + 8'(i), prog[i]);
		wr(8'h46, 8'hFF);
		wr(8'h4F, 8'hFF);
		rd(8'h46, 8'h00);
		rd(8'h4F, 8'h00);
		rd(ADDR_FIRST, prog[0]);
		rd(ADDR_LAST, prog[7]);
		wait_period(3);
		edge_chk(0, 12'd10, 12'd150);
		edge_chk(1, 12'd20, 12'd60);
		edge_chk(2, 12'd100, 12'd180);
		wr_rd(ADDR_C_RISE_SETTING, 8'hE0);
		wait_period(3);
		edge_chk(1, 12'd30, 12'd60);
		wr(ADDR_C_FALL_SETTING, 8'h00);
		wait_period(3);
		edge_chk(1, 12'd30, 12'd48);
		wr(ADDR_C_FALL_SETTING, 8'hC0);
		mod_value = 8'd30;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_C_RISE_SETTING, sets[i]);
			wait_period(3);
			edge_chk(1, mexp[i], 12'd60);
		end
		wr(ADDR_B_FALL_SETTING, 8'h6C);
		wr(ADDR_D_RISE_SETTING, 8'h48);
		wait_period(3);
		edge_chk(0, 12'd10, 12'd180);
		edge_chk(2, 12'd70, 12'd180);
		mod_value = 8'd0;
		wr(ADDR_C_RISE_SETTING, 8'h40);
		wait_period(3);
		wr(ADDR_C_RISE_TIME_HIGH, 8'h05);
		wait_period(1);
		edge_chk(1, 12'd20, 12'd60);
		wait_period(1);
		edge_chk(1, 12'd84, 12'd60);
		test_done();
	end
endmodule
